/* aie_core.sv */
// Execution datapath for add literal, add W to file, add with carry, AND
// Overview of operation
// - Add-to-file opcode adds W to file register chosen by 8-bit field.
// - Destination bit zero writes result to W, file unchanged.
// - Destination bit one writes result back into the file register.
// - Access bit zero selects access bank; one uses bank select register.
// - Extended set, access zero, address up to 95: indexed literal offset.
// - Add-with-carry sums W, carry flag and file register.
// - Add-with-carry: destination one to memory, zero to W.
// - Adds update negative, overflow, carry, digit carry and zero flags.
// - AND literal: W AND 8-bit literal, result into W.
// - AND literal decoded from upper byte 0000 1011.
// - AND literal updates only negative and zero flags.
`timescale 1ns/1ns
`default_nettype none
module aie_core
    import aie_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [INSTR_W-1:0] INSTR,
    input wire logic INSTR_VALID,
    output logic BUSY,
    output logic DONE,
    input wire logic [BANK_W-1:0] BANK_SELECT,
    input wire logic EXT_SET_EN,
    input wire logic [DADDR_W-1:0] INDEX_BASE,
    input wire logic [DADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    output logic [DATA_W-1:0] WORK_REG,
    output logic FLAG_N,
    output logic FLAG_OV,
    output logic FLAG_Z,
    output logic FLAG_DC,
    output logic FLAG_C
);

    // ==========================================================
    // Decode helpers
    function automatic aie_op_t op_class(input logic [INSTR_W-1:0] w);
        aie_op_t k;
        k = OP_NONE;
        if (w[15:8] == OPC_ADD_LIT) begin
            k = OP_ADD_LIT;
        end else if (w[15:8] == OPC_AND_LIT) begin
            k = OP_AND_LIT;
        end else if (w[15:10] == OPC_ADD_WF) begin
            k = OP_ADD_WF;
        end else if (w[15:10] == OPC_ADD_WFC) begin
            k = OP_ADD_WFC;
        end
        return k;
    endfunction : op_class

    function automatic logic [DADDR_W-1:0] file_addr(
        input logic [INSTR_W-1:0] w,
        input logic [BANK_W-1:0] bank,
        input logic ext,
        input logic [DADDR_W-1:0] base
    );
        logic [7:0] f;
        logic [DADDR_W-1:0] a;
        f = w[7:0];
        if (w[POS_ACCESS]) begin
            a = {bank, f};
        end else if (ext && f <= INDEXED_MAX) begin
            a = base + {4'h0, f};
        end else if (f < ACCESS_SPLIT) begin
            a = {ACCESS_LOW_BANK, f};
        end else begin
            a = {ACCESS_HIGH_BANK, f};
        end
        return a;
    endfunction : file_addr

    // ==========================================================
    // State and datapath registers
    aie_state_t state_r, state_nxt;
    logic [INSTR_W-1:0] instr_r;
    logic [DADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] operand_r;
    logic [DATA_W-1:0] result_r;
    logic [DATA_W-1:0] work_r;
    logic n_r, ov_r, z_r, dc_r, c_r;
    logic n_nxt, ov_nxt, z_nxt, dc_nxt, c_nxt;
    logic [DATA_W-1:0] result_nxt;

    // ==========================================================
    // Decoded fields of the held word
    aie_op_t op;
    assign op = op_class(instr_r);
    wire is_file = (op == OP_ADD_WF) || (op == OP_ADD_WFC);
    wire is_add = (op == OP_ADD_LIT) || is_file;
    wire dest_file = is_file && instr_r[POS_DEST];
    wire taken = INSTR_VALID && (state_r == ST_IDLE);
    wire [DADDR_W-1:0] addr_calc =
        file_addr(instr_r, BANK_SELECT, EXT_SET_EN, INDEX_BASE);
    wire [DADDR_W-1:0] core_addr = (state_r == ST_DECODE) ? addr_calc : addr_r;
    wire core_we = (state_r == ST_WRITE) && dest_file;
    wire [DATA_W-1:0] mem_rdata;

    // ==========================================================
    // Adder: carry in only for the carry variant
    wire cin = (op == OP_ADD_WFC) ? c_r : 1'b0;
    wire [DATA_W:0] sum9 = {1'b0, work_r} + {1'b0, operand_r}
        + {8'h00, cin};
    wire [4:0] nib5 = {1'b0, work_r[3:0]} + {1'b0, operand_r[3:0]}
        + {4'h0, cin};
    wire [DATA_W-1:0] and8 = work_r & operand_r;

    // ==========================================================
    // Result and flag selection; result taken in the process phase, flags in the write phase
    always_comb begin
        result_nxt = result_r;
        n_nxt = n_r;
        ov_nxt = ov_r;
        z_nxt = z_r;
        dc_nxt = dc_r;
        c_nxt = c_r;
        if (is_add) begin
            result_nxt = sum9[7:0];
            n_nxt = sum9[7];
            z_nxt = (sum9[7:0] == 8'h00);
            c_nxt = sum9[8];
            dc_nxt = nib5[4];
            ov_nxt = (work_r[7] == operand_r[7]) && (sum9[7] != work_r[7]);
        end else if (op == OP_AND_LIT) begin
            // Carry, digit carry and overflow are left alone
            result_nxt = and8;
            n_nxt = and8[7];
            z_nxt = (and8 == 8'h00);
        end
    end

    // ==========================================================
    // Phase sequencer, one phase per clock
    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = taken ? ST_DECODE : ST_IDLE;
            ST_DECODE: state_nxt = ST_READ;
            ST_READ: state_nxt = ST_PROC;
            ST_PROC: state_nxt = ST_WRITE;
            ST_WRITE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Word, address and operand capture
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            instr_r <= '0;
            addr_r <= '0;
            operand_r <= '0;
        end else begin
            if (taken) begin
                instr_r <= INSTR;
            end
            if (state_r == ST_DECODE) begin
                addr_r <= addr_calc;
            end
            if (state_r == ST_READ) begin
                // Literal forms never touch memory
                operand_r <= is_file ? mem_rdata : instr_r[7:0];
            end
        end
    end

    // ==========================================================
    // Process and write-back
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            result_r <= '0;
            work_r <= WORK_RST;
            {n_r, ov_r, z_r, dc_r, c_r} <= {5{FLAG_RST}};
        end else begin
            if (state_r == ST_PROC) begin
                result_r <= result_nxt;
            end
            if (state_r == ST_WRITE) begin
                {n_r, ov_r, z_r, dc_r, c_r} <=
                    {n_nxt, ov_nxt, z_nxt, dc_nxt, c_nxt};
                if (op != OP_NONE && !dest_file) begin
                    work_r <= result_r;
                end
            end
        end
    end

    // ==========================================================
    // Data memory shared with the software port
    aie_dmem u_dmem (
        .clk(MCLK),
        .rst(SYS_RST),
        .a_addr(core_addr),
        .a_we(core_we),
        .a_wdata(result_r),
        .a_rdata(mem_rdata),
        .b_addr(ADDR),
        .b_we(WR),
        .b_re(RD),
        .b_wdata(WDATA),
        .b_rdata(RDATA)
    );

    // ==========================================================
    // Outputs
    assign BUSY = (state_r != ST_IDLE);
    assign DONE = (state_r == ST_WRITE);
    assign WORK_REG = work_r;
    assign FLAG_N = n_r;
    assign FLAG_OV = ov_r;
    assign FLAG_Z = z_r;
    assign FLAG_DC = dc_r;
    assign FLAG_C = c_r;

    // ==========================================================
    // Checks
    // One clock domain, so the checks share one clock and one reset gate
    default clocking chk_cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    chk_add_working_to_file_sum: assert property (
        (state_r == ST_PROC && op == OP_ADD_WF)
        |=> result_r == $past(work_r) + $past(operand_r))
        else $error("add to file sum wrong");

    chk_dest_work: assert property (
        (state_r == ST_WRITE && is_file && !instr_r[POS_DEST])
        |-> !core_we ##1 work_r == $past(result_r))
        else $error("destination zero did not go to W");

    chk_dest_file: assert property (
        (state_r == ST_WRITE && is_file && instr_r[POS_DEST])
        |-> core_we && core_addr == addr_r ##1 $stable(work_r))
        else $error("destination one did not write file");

    chk_bank_select: assert property (
        (state_r == ST_DECODE && instr_r[POS_ACCESS])
        |=> addr_r == {$past(BANK_SELECT), instr_r[7:0]})
        else $error("bank select address wrong");

    chk_indexed_mode: assert property (
        (state_r == ST_DECODE && !instr_r[POS_ACCESS] && EXT_SET_EN
        && instr_r[7:0] <= INDEXED_MAX)
        |=> addr_r == $past(INDEX_BASE) + {4'h0, instr_r[7:0]})
        else $error("indexed literal offset address wrong");

    chk_carry_in: assert property (
        (state_r == ST_PROC && op == OP_ADD_WFC)
        |=> result_r == 8'($past(work_r) + $past(operand_r)
        + {7'h00, $past(c_r)}))
        else $error("carry not added");

    chk_wfc_dest: assert property (
        (state_r == ST_WRITE && op == OP_ADD_WFC)
        |-> core_we == instr_r[POS_DEST])
        else $error("add with carry destination wrong");

    chk_add_flags: assert property (
        (state_r == ST_WRITE && is_add)
        |=> FLAG_C == $past(sum9[8]) && FLAG_Z == (result_r == 8'h00)
        && FLAG_DC == $past(nib5[4]) && FLAG_N == result_r[7])
        else $error("add flags wrong");

    // Signed overflow worked out from the operand signs, not from the adder
    chk_add_overflow: assert property (
        (state_r == ST_WRITE && is_add)
        |=> FLAG_OV == (($past(work_r[7]) == $past(operand_r[7]))
        && (result_r[7] != $past(work_r[7]))))
        else $error("add overflow flag wrong");

    chk_and_result: assert property (
        (state_r == ST_READ && instr_r[15:8] == OPC_AND_LIT)
        |-> ##3 work_r == ($past(work_r, 3) & instr_r[7:0]))
        else $error("AND literal result wrong");

    chk_and_flags: assert property (
        (state_r == ST_WRITE && op == OP_AND_LIT)
        |=> $stable(FLAG_C) && $stable(FLAG_DC) && $stable(FLAG_OV)
        && FLAG_Z == (work_r == 8'h00))
        else $error("AND literal touched arithmetic flags");

    chk_add_literal: assert property (
        (state_r == ST_READ && instr_r[15:8] == OPC_ADD_LIT)
        |-> ##3 work_r == 8'($past(work_r, 3) + instr_r[7:0]))
        else $error("add literal result wrong");

    chk_four_phase: assert property (
        taken |=> BUSY [*3] ##1 DONE ##1 !BUSY)
        else $error("instruction did not take four phases");

endmodule : aie_core
`default_nettype wire

/* aie_pkg.sv */
// Constants and types shared by the add/AND instruction datapath
package aie_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int DADDR_W = 12;
    localparam int DMEM_DEPTH = 4096;

    // ==========================================================
    // Opcode fields
    localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
    localparam logic [7:0] OPC_AND_LIT = 8'h0B;
    localparam logic [5:0] OPC_ADD_WF = 6'h09;
    localparam logic [5:0] OPC_ADD_WFC = 6'h08;
    localparam int POS_DEST = 9;
    localparam int POS_ACCESS = 8;

    // ==========================================================
    // Data memory addressing
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_READ = 3'b010,
        ST_PROC = 3'b011,
        ST_WRITE = 3'b100
    } aie_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ADD_LIT = 3'b001,
        OP_AND_LIT = 3'b010,
        OP_ADD_WF = 3'b011,
        OP_ADD_WFC = 3'b100
    } aie_op_t;

endpackage : aie_pkg

/* aie_dmem.sv */
// Two-port data memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module aie_dmem
    import aie_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [DADDR_W-1:0] a_addr,
    input wire logic a_we,
    input wire logic [DATA_W-1:0] a_wdata,
    output logic [DATA_W-1:0] a_rdata,
    input wire logic [DADDR_W-1:0] b_addr,
    input wire logic b_we,
    input wire logic b_re,
    input wire logic [DATA_W-1:0] b_wdata,
    output logic [DATA_W-1:0] b_rdata
);

    logic [DATA_W-1:0] mem [0:DMEM_DEPTH-1];

    // ==========================================================
    // Storage; core port wins a same-address write clash
    always_ff @(posedge clk) begin
        if (b_we && !(a_we && a_addr == b_addr)) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
    end

    // ==========================================================
    // Registered read ports
    always_ff @(posedge clk) begin
        if (rst) begin
            a_rdata <= '0;
            b_rdata <= '0;
        end else begin
            a_rdata <= mem[a_addr];
            if (b_re) begin
                b_rdata <= mem[b_addr];
            end
        end
    end

endmodule : aie_dmem
`default_nettype wire

/* aie_tb.sv */
// Self-checking testbench for the add and AND instruction datapath
`timescale 1ns/1ns
`default_nettype none
module testbench
    import aie_pkg::*;
;
    // ==========================================================
    // Clock, stimulus and observation
    logic MCLK, SYS_RST, INSTR_VALID, EXT_SET_EN, WR, RD;
    logic [INSTR_W-1:0] INSTR;
    logic [BANK_W-1:0] BANK_SELECT;
    logic [DADDR_W-1:0] INDEX_BASE, ADDR;
    logic [DATA_W-1:0] WDATA, RDATA, WORK_REG;
    logic BUSY, DONE, FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C;
    wire logic [4:0] flags;
    int n_fail = 0;
    int n_checks = 0;
    logic [7:0] exp_w;
    logic [4:0] exp_f;
    assign flags = {FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C};

    aie_core dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSTR(INSTR),
        .INSTR_VALID(INSTR_VALID), .BUSY(BUSY), .DONE(DONE),
        .BANK_SELECT(BANK_SELECT), .EXT_SET_EN(EXT_SET_EN),
        .INDEX_BASE(INDEX_BASE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .WORK_REG(WORK_REG), .FLAG_N(FLAG_N),
        .FLAG_OV(FLAG_OV), .FLAG_Z(FLAG_Z), .FLAG_DC(FLAG_DC),
        .FLAG_C(FLAG_C));

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    // ==========================================================
    // Compares and closing report
    task automatic chk8(input logic [7:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic chk5(input logic [4:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk5

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Reference sum with flags packed {sum, N, OV, Z, DC, C}
    function automatic logic [12:0] add_exp(input logic [7:0] a, b,
        input logic cin);
        logic [8:0] s;
        logic [4:0] lo;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {s[7:0], s[7], (a[7] == b[7]) && (s[7] != a[7]),
            s[7:0] == 8'h00, lo[4], s[8]};
    endfunction : add_exp

    // ==========================================================
    // Bus and instruction helpers
    task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : mem_wr

    task automatic mem_rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        chk8(RDATA, exp, "file register");
    endtask : mem_rd

    // Launch one word and wait, bounded, for the write phase
    task automatic exec(input logic [15:0] w);
        int cnt;
        @(posedge MCLK);
        INSTR <= w;
        INSTR_VALID <= 1'b1;
        @(posedge MCLK);
        INSTR_VALID <= 1'b0;
        #1;
        cnt = 1;
        while (DONE !== 1'b1) begin
            if (cnt >= 8) begin
                chk8(8'h00, 8'h01, "done timeout");
                finish_test();
            end
            @(posedge MCLK);
            #1;
            cnt++;
        end
        chk8(8'(cnt), 8'h04, "done latency");
        @(posedge MCLK);
        #1;
        chk8(8'(BUSY), 8'h00, "busy after done");
    endtask : exec

    task automatic do_lit(input logic is_and, input logic [7:0] k);
        logic [12:0] r;
        exec({is_and ? OPC_AND_LIT : OPC_ADD_LIT, k});
        r = add_exp(exp_w, k, 1'b0);
        if (is_and) begin
            exp_w = exp_w & k;
            exp_f = {exp_w[7], exp_f[3], exp_w == 8'h00, exp_f[1:0]};
        end else begin
            exp_w = r[12:5];
            exp_f = r[4:0];
        end
        chk8(WORK_REG, exp_w, "literal result");
        chk5(flags, exp_f, "literal flags");
    endtask : do_lit

    // File operand add; pa is the location the rules select
    task automatic do_file(input logic [5:0] opc, input logic d, a,
        input logic [7:0] f, input logic [11:0] pa, input logic [7:0] fv);
        logic [12:0] r;
        r = add_exp(exp_w, fv, (opc == OPC_ADD_WFC) ? exp_f[0] : 1'b0);
        mem_wr(pa, fv);
        exec({opc, d, a, f});
        mem_rd(pa, d ? r[12:5] : fv);
        if (!d) begin
            exp_w = r[12:5];
        end
        exp_f = r[4:0];
        chk8(WORK_REG, exp_w, "working result");
        chk5(flags, exp_f, "add flags");
    endtask : do_file

    // ==========================================================
    // Scenarios
    task automatic t_literals();
        do_lit(1'b1, 8'h00);
        do_lit(1'b0, 8'h10);
        do_lit(1'b0, 8'h15);
        do_lit(1'b0, 8'hDB);
        do_lit(1'b0, 8'h7F);
        do_lit(1'b0, 8'h01);
        do_lit(1'b0, 8'hF3);
        do_lit(1'b1, 8'hF0);
        do_lit(1'b1, 8'h0F);
    endtask : t_literals

    task automatic t_banks();
        do_lit(1'b0, 8'h17);
        do_file(OPC_ADD_WF, 1'b0, 1'b0, 8'h20, 12'h020, 8'hC2);
        @(posedge MCLK);
        BANK_SELECT <= 4'h3;
        do_file(OPC_ADD_WF, 1'b1, 1'b1, 8'hFF, 12'h3FF, 8'h05);
        do_file(OPC_ADD_WF, 1'b1, 1'b0, 8'h80, 12'hF80, 8'h9A);
        do_file(OPC_ADD_WF, 1'b0, 1'b0, 8'h5F, 12'h05F, 8'h44);
    endtask : t_banks

    task automatic t_carry();
        do_lit(1'b1, 8'h00);
        do_lit(1'b0, 8'h4E);
        do_lit(1'b0, 8'hFF);
        do_file(OPC_ADD_WFC, 1'b0, 1'b1, 8'h02, 12'h302, 8'h02);
        do_lit(1'b0, 8'hC0);
        do_file(OPC_ADD_WFC, 1'b1, 1'b1, 8'h03, 12'h303, 8'hF0);
        do_file(OPC_ADD_WFC, 1'b1, 1'b0, 8'h04, 12'h004, 8'h0F);
    endtask : t_carry

    task automatic t_indexed();
        @(posedge MCLK);
        EXT_SET_EN <= 1'b1;
        INDEX_BASE <= 12'h200;
        mem_wr(12'h05F, 8'h00);
        do_file(OPC_ADD_WF, 1'b1, 1'b0, 8'h5F, 12'h25F, 8'h21);
        do_file(OPC_ADD_WFC, 1'b0, 1'b0, 8'h60, 12'hF60, 8'h81);
        do_file(OPC_ADD_WF, 1'b0, 1'b1, 8'h10, 12'h310, 8'h11);
        @(posedge MCLK);
        EXT_SET_EN <= 1'b0;
    endtask : t_indexed

    // A second request while busy is dropped; unknown word does nothing
    task automatic t_busy();
        logic [12:0] r;
        @(posedge MCLK);
        INSTR <= {OPC_ADD_LIT, 8'h01};
        INSTR_VALID <= 1'b1;
        @(posedge MCLK);
        INSTR <= {OPC_AND_LIT, 8'h00};
        @(posedge MCLK);
        INSTR_VALID <= 1'b0;
        repeat (8) @(posedge MCLK);
        #1;
        r = add_exp(exp_w, 8'h01, 1'b0);
        exp_f = r[4:0];
        exp_w = r[12:5];
        chk8(WORK_REG, exp_w, "busy refusal");
        chk5(flags, exp_f, "busy flags");
        exec(16'hFFFF);
        chk8(WORK_REG, exp_w, "unknown word");
        chk5(flags, exp_f, "unknown word flags");
    endtask : t_busy

    // ==========================================================
    // Main sequence
    initial begin
        SYS_RST = 1'b1;
        INSTR_VALID = 1'b0;
        INSTR = 16'h0000;
        BANK_SELECT = 4'h0;
        EXT_SET_EN = 1'b0;
        INDEX_BASE = 12'h000;
        ADDR = 12'h000;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        exp_w = WORK_RST;
        exp_f = 5'h00;
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        #1;
        chk8(WORK_REG, WORK_RST, "reset working");
        chk5(flags, 5'h00, "reset flags");
        chk8({6'h00, BUSY, DONE}, 8'h00, "reset busy done");
        t_literals();
        t_banks();
        t_carry();
        t_indexed();
        t_busy();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
